// *** rtl/timer8_pkg.sv ***
// Package of constants and carrier types for the 8-bit timer/counter
package timer8_pkg;

   // ==========================================
   // Counter values
   localparam logic [7:0] CNT_BOTTOM = 8'h00;
   localparam logic [7:0] CNT_MAX    = 8'hFF;
   localparam logic [7:0] CNT_RESET  = 8'h00;

   // ==========================================
   // Waveform modes
   localparam logic [1:0] WGM_NORMAL = 2'h0;
   localparam logic [1:0] WGM_PCPWM  = 2'h1;
   localparam logic [1:0] WGM_CTC    = 2'h2;
   localparam logic [1:0] WGM_FAST   = 2'h3;

   // ==========================================
   // Output actions
   localparam logic [1:0] COM_OFF    = 2'h0;
   localparam logic [1:0] COM_TOGGLE = 2'h1;
   localparam logic [1:0] COM_CLEAR  = 2'h2;
   localparam logic [1:0] COM_SET    = 2'h3;

   // ==========================================
   // Clock select codes
   localparam logic [2:0] CS_STOP  = 3'h0;
   localparam logic [2:0] CS_DIV1  = 3'h1;
   localparam logic [2:0] CS_DIV8  = 3'h2;
   localparam logic [2:0] CS_DIV64 = 3'h3;
   localparam logic [2:0] CS_DIV256  = 3'h4;
   localparam logic [2:0] CS_DIV1024 = 3'h5;
   localparam logic [2:0] CS_EXT_FALL = 3'h6;
   localparam logic [2:0] CS_EXT_RISE = 3'h7;

   // ==========================================
   // Prescaler
   localparam int          PRESCALE_W = 10;
   localparam logic [9:0]  PRE_RESET  = 10'h000;
   localparam logic [9:0]  PRE_ONE    = 10'h001;
   localparam logic [9:0]  MASK_DIV8    = 10'h007;
   localparam logic [9:0]  MASK_DIV64   = 10'h03F;
   localparam logic [9:0]  MASK_DIV256  = 10'h0FF;
   localparam logic [9:0]  MASK_DIV1024 = 10'h3FF;

   // ==========================================
   // Carrier types
   typedef struct packed {
      logic [2:0] clock_select;
      logic [1:0] waveform_mode;
      logic [1:0] output_action;
   } timer_ctrl_t;

   typedef struct packed {
      logic bottom;
      logic max;
      logic top;
   } count_state_t;

endpackage

// *** rtl/timer8_tick_gen.sv ***
// Timer tick generator: prescaler taps and synchronised external pin edges
`timescale 1ns/100ps
`default_nettype none

module timer8_tick_gen
   import timer8_pkg::*;
(
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rst_n,
   // Control
   input  wire logic [2:0] clock_select,
   input  wire logic       prescale_clear,
   // Pin
   input  wire logic       ext_count_pin,
   // Tick
   output logic            timer_tick
);

   logic [PRESCALE_W-1:0] pre_reg;
   logic [2:0]            pin_sync_reg;
   logic                  pin_level_reg;
   logic                  rise;
   logic                  fall;

   // ==========================================
   // Free-running prescaler
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pre_reg <= PRE_RESET;
      end else if (prescale_clear) begin
         pre_reg <= PRE_RESET;
      end else begin
         pre_reg <= pre_reg + PRE_ONE;
      end
   end

   // ==========================================
   // Pin synchroniser; stages two and three must agree
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_sync_reg <= 3'h0;
      end else begin
         pin_sync_reg <= {pin_sync_reg[1:0], ext_count_pin};
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_level_reg <= 1'h0;
      end else if (pin_sync_reg[1] == pin_sync_reg[2]) begin
         pin_level_reg <= pin_sync_reg[2];
      end
   end

   assign rise = (pin_sync_reg[1] == pin_sync_reg[2]) &&
                 pin_sync_reg[2] && !pin_level_reg;
   assign fall = (pin_sync_reg[1] == pin_sync_reg[2]) &&
                 !pin_sync_reg[2] && pin_level_reg;

   // ==========================================
   // Source select
   always_comb begin
      unique case (clock_select)
         CS_STOP:     timer_tick = 1'b0;
         CS_DIV1:     timer_tick = 1'b1;
         CS_DIV8:     timer_tick = (pre_reg & MASK_DIV8) == MASK_DIV8;
         CS_DIV64:    timer_tick = (pre_reg & MASK_DIV64) == MASK_DIV64;
         CS_DIV256:   timer_tick = (pre_reg & MASK_DIV256) == MASK_DIV256;
         CS_DIV1024:  timer_tick = pre_reg == MASK_DIV1024;
         CS_EXT_FALL: timer_tick = fall;
         CS_EXT_RISE: timer_tick = rise;
      endcase
   end

   chk_stop_no_tick: assert property (
      @(posedge clk) disable iff (!rst_n)
      clock_select == CS_STOP |-> !timer_tick)
      else $error("tick while stopped");

   chk_div8_spacing: assert property (
      @(posedge clk) disable iff (!rst_n)
      (clock_select == CS_DIV8 && timer_tick && !prescale_clear)
      ##1 (clock_select == CS_DIV8 && !prescale_clear) [*8]
      |-> timer_tick && !$past(timer_tick))
      else $error("divide by eight spacing wrong");

endmodule

`default_nettype wire

// *** rtl/timer8_counter_compare_unit.sv ***
// 8-bit timer/counter with output compare and compare match output unit
`timescale 1ns/100ps
`default_nettype none

module timer8_counter_compare_unit
   import timer8_pkg::*;
(
   // Clock and reset
   input  wire logic        SYS_CLK,
   input  wire logic        RSTN,
   // Control
   input  wire timer_ctrl_t CTRL,
   input  wire logic        PRESCALE_CLEAR,
   input  wire logic        FORCE_MATCH,
   // Counter access
   input  wire logic        CNT_WR,
   input  wire logic [7:0]  CNT_WDATA,
   output logic      [7:0]  CNT_RDATA,
   // Compare access
   input  wire logic        CMP_WR,
   input  wire logic [7:0]  CMP_WDATA,
   output logic      [7:0]  CMP_RDATA,
   // Flags and masks
   input  wire logic        MATCH_FLAG_WR1,
   input  wire logic        OVF_FLAG_WR1,
   input  wire logic        MATCH_SERVICED,
   input  wire logic        OVF_SERVICED,
   input  wire logic        MATCH_INT_EN,
   input  wire logic        OVF_INT_EN,
   input  wire logic        GLOBAL_INT_EN,
   output logic             MATCH_FLAG,
   output logic             OVERFLOW_FLAG,
   output logic             MATCH_IRQ,
   output logic             OVF_IRQ,
   // Pins
   input  wire logic        EXT_COUNT_PIN,
   input  wire logic        PORT_DATA,
   input  wire logic        WAVE_PIN_DIR,
   output logic             WAVE_PIN_O,
   output logic             WAVE_PIN_OE,
   output logic             WAVE_OUT
);

   logic [7:0]   cnt_reg;
   logic [7:0]   cnt_next;
   logic [7:0]   cmp_active_reg;
   logic [7:0]   cmp_buf_reg;
   logic         block_reg;
   logic         match_flag_reg;
   logic         ovf_flag_reg;
   logic         wave_reg;
   logic         wave_next;
   logic         timer_tick;
   logic         match;
   logic         buffered;
   count_state_t cs;

   function automatic logic is_pwm(input logic [1:0] mode);
      return mode == WGM_PCPWM || mode == WGM_FAST;
   endfunction

   function automatic logic apply_action(input logic [1:0] act,
                                         input logic       cur);
      unique case (act)
         COM_OFF:    return cur;
         COM_TOGGLE: return !cur;
         COM_CLEAR:  return 1'b0;
         COM_SET:    return 1'b1;
      endcase
   endfunction

   // ==========================================
   // Tick source
   timer8_tick_gen u_tick (
      .clk            (SYS_CLK),
      .rst_n          (RSTN),
      .clock_select   (CTRL.clock_select),
      .prescale_clear (PRESCALE_CLEAR),
      .ext_count_pin  (EXT_COUNT_PIN),
      .timer_tick     (timer_tick)
   );

   // ==========================================
   // Extremes and compare
   assign buffered = is_pwm(CTRL.waveform_mode);
   assign cs.bottom = cnt_reg == CNT_BOTTOM;
   assign cs.max    = cnt_reg == CNT_MAX;
   assign cs.top    = (CTRL.waveform_mode == WGM_CTC) ?
                      (cnt_reg == cmp_active_reg) : cs.max;
   assign match = (cnt_reg == cmp_active_reg) && !block_reg;

   // ==========================================
   // Counter next value
   always_comb begin
      cnt_next = cnt_reg;
      if (timer_tick) begin
         unique case (CTRL.waveform_mode)
            WGM_NORMAL: cnt_next = cnt_reg + 8'h01;
            WGM_CTC:    cnt_next = cs.top ? CNT_BOTTOM :
                                   cnt_reg + 8'h01;
            WGM_FAST:   cnt_next = cs.max ? CNT_BOTTOM :
                                   cnt_reg + 8'h01;
            WGM_PCPWM:  cnt_next = cs.max ? cnt_reg - 8'h01 :
                                   cnt_reg + 8'h01;
         endcase
      end
   end

   always_ff @(posedge SYS_CLK or negedge RSTN) begin
      if (!RSTN) begin
         cnt_reg <= CNT_RESET;
      end else if (CNT_WR) begin
         cnt_reg <= CNT_WDATA;
      end else begin
         cnt_reg <= cnt_next;
      end
   end

   assign CNT_RDATA = cnt_reg;

   // Block holds until the next tick has passed
   always_ff @(posedge SYS_CLK or negedge RSTN) begin
      if (!RSTN) begin
         block_reg <= 1'b0;
      end else if (CNT_WR) begin
         block_reg <= 1'b1;
      end else if (timer_tick) begin
         block_reg <= 1'b0;
      end
   end

   // ==========================================
   // Compare registers
   always_ff @(posedge SYS_CLK or negedge RSTN) begin
      if (!RSTN) begin
         cmp_buf_reg <= CNT_RESET;
      end else if (CMP_WR) begin
         cmp_buf_reg <= CMP_WDATA;
      end
   end

   always_ff @(posedge SYS_CLK or negedge RSTN) begin
      if (!RSTN) begin
         cmp_active_reg <= CNT_RESET;
      end else if (!buffered && CMP_WR) begin
         cmp_active_reg <= CMP_WDATA;
      end else if (buffered && timer_tick && (cs.max || cs.bottom)) begin
         cmp_active_reg <= cmp_buf_reg;
      end
   end

   assign CMP_RDATA = buffered ? cmp_buf_reg : cmp_active_reg;

   // ==========================================
   // Flags; set wins over clear
   always_ff @(posedge SYS_CLK or negedge RSTN) begin
      if (!RSTN) begin
         match_flag_reg <= 1'b0;
      end else if (timer_tick && match) begin
         match_flag_reg <= 1'b1;
      end else if (MATCH_FLAG_WR1 || MATCH_SERVICED) begin
         match_flag_reg <= 1'b0;
      end
   end

   always_ff @(posedge SYS_CLK or negedge RSTN) begin
      if (!RSTN) begin
         ovf_flag_reg <= 1'b0;
      end else if (timer_tick && !CNT_WR && cs.max &&
                   CTRL.waveform_mode != WGM_PCPWM) begin
         ovf_flag_reg <= 1'b1;
      end else if (timer_tick && !CNT_WR && cs.bottom &&
                   CTRL.waveform_mode == WGM_PCPWM) begin
         ovf_flag_reg <= 1'b1;
      end else if (OVF_FLAG_WR1 || OVF_SERVICED) begin
         ovf_flag_reg <= 1'b0;
      end
   end

   assign MATCH_FLAG    = match_flag_reg;
   assign OVERFLOW_FLAG = ovf_flag_reg;
   assign MATCH_IRQ = match_flag_reg && MATCH_INT_EN && GLOBAL_INT_EN;
   assign OVF_IRQ   = ovf_flag_reg && OVF_INT_EN && GLOBAL_INT_EN;

   // ==========================================
   // Waveform generator
   always_comb begin
      wave_next = wave_reg;
      if (FORCE_MATCH && !buffered) begin
         wave_next = apply_action(CTRL.output_action, wave_reg);
      end else if (timer_tick) begin
         if (CTRL.waveform_mode == WGM_FAST &&
             CTRL.output_action[1]) begin
            if (match && !cs.max) begin
               wave_next = CTRL.output_action[0];
            end else if (cs.max && cmp_active_reg != CNT_MAX) begin
               wave_next = !CTRL.output_action[0];
            end else if (cs.max) begin
               wave_next = CTRL.output_action[0] ? 1'b0 : 1'b1;
            end
         end else if (match) begin
            wave_next = apply_action(CTRL.output_action, wave_reg);
         end
      end
   end

   always_ff @(posedge SYS_CLK or negedge RSTN) begin
      if (!RSTN) begin
         wave_reg <= 1'b0;
      end else begin
         wave_reg <= wave_next;
      end
   end

   // ==========================================
   // Pin override
   assign WAVE_OUT    = wave_reg;
   assign WAVE_PIN_O  = (CTRL.output_action != COM_OFF) ?
                        wave_reg : PORT_DATA;
   assign WAVE_PIN_OE = WAVE_PIN_DIR;

   // ==========================================
   // Checks
   chk_write_priority: assert property (
      @(posedge SYS_CLK) disable iff (!RSTN)
      CNT_WR |=> cnt_reg == $past(CNT_WDATA))
      else $error("counter write lost");

   chk_stop_holds: assert property (
      @(posedge SYS_CLK) disable iff (!RSTN)
      CTRL.clock_select == CS_STOP && !CNT_WR |=> $stable(cnt_reg))
      else $error("counter moved while stopped");

   chk_normal_count: assert property (
      @(posedge SYS_CLK) disable iff (!RSTN)
      timer_tick && !CNT_WR && CTRL.waveform_mode == WGM_NORMAL
      |=> cnt_reg == $past(cnt_reg) + 8'h01)
      else $error("normal mode increment wrong");

   chk_ctc_clear: assert property (
      @(posedge SYS_CLK) disable iff (!RSTN)
      timer_tick && !CNT_WR && CTRL.waveform_mode == WGM_CTC &&
      cnt_reg == cmp_active_reg |=> cnt_reg == CNT_BOTTOM)
      else $error("clear on match missed");

   chk_match_flag_set: assert property (
      @(posedge SYS_CLK) disable iff (!RSTN)
      timer_tick && match |=> match_flag_reg)
      else $error("match flag not set");

   chk_block_match: assert property (
      @(posedge SYS_CLK) disable iff (!RSTN)
      CNT_WR ##1 (timer_tick && !match_flag_reg && !MATCH_FLAG_WR1)
      |=> !match_flag_reg)
      else $error("blocked match set flag");

   chk_irq_gate: assert property (
      @(posedge SYS_CLK) disable iff (!RSTN)
      MATCH_IRQ |-> MATCH_INT_EN && GLOBAL_INT_EN && match_flag_reg)
      else $error("match request not gated");

   chk_force_no_flag: assert property (
      @(posedge SYS_CLK) disable iff (!RSTN)
      FORCE_MATCH && !timer_tick && !match_flag_reg |=> !match_flag_reg)
      else $error("force set match flag");

   chk_direct_cmp: assert property (
      @(posedge SYS_CLK) disable iff (!RSTN)
      CMP_WR && !buffered |=> cmp_active_reg == $past(CMP_WDATA))
      else $error("direct compare write lost");

   chk_off_holds: assert property (
      @(posedge SYS_CLK) disable iff (!RSTN)
      CTRL.output_action == COM_OFF && !(CTRL.waveform_mode == WGM_FAST)
      |=> $stable(wave_reg))
      else $error("wave output changed with action off");

   cov_ctc_wrap: cover property (@(posedge SYS_CLK) disable iff (!RSTN)
      CTRL.waveform_mode == WGM_CTC && timer_tick && match);
   cov_overflow: cover property (@(posedge SYS_CLK) disable iff (!RSTN)
      $rose(ovf_flag_reg));
   cov_force: cover property (@(posedge SYS_CLK) disable iff (!RSTN)
      FORCE_MATCH && CTRL.output_action == COM_TOGGLE);
   cov_buffer_load: cover property (@(posedge SYS_CLK) disable iff (!RSTN)
      buffered && timer_tick && (cs.max || cs.bottom) &&
      cmp_buf_reg != cmp_active_reg);

endmodule

`default_nettype wire

// *** verification/timer8_counter_compare_unit_tb.sv ***
// Self-checking testbench for the 8-bit timer/counter with compare unit
`timescale 1ns/100ps
`default_nettype none

module timer8_counter_compare_unit_tb
   import timer8_pkg::*;
   ;
   // ==========================================
   // Stimulus and observed signals
   logic        SYS_CLK, RSTN, PRESCALE_CLEAR, FORCE_MATCH;
   timer_ctrl_t CTRL;
   logic        CNT_WR, CMP_WR, MATCH_FLAG_WR1, OVF_FLAG_WR1;
   logic [7:0]  CNT_WDATA, CNT_RDATA, CMP_WDATA, CMP_RDATA;
   logic        MATCH_SERVICED, OVF_SERVICED, MATCH_INT_EN, OVF_INT_EN;
   logic        GLOBAL_INT_EN, MATCH_FLAG, OVERFLOW_FLAG, MATCH_IRQ;
   logic        OVF_IRQ, EXT_COUNT_PIN, PORT_DATA, WAVE_PIN_DIR;
   logic        WAVE_PIN_O, WAVE_PIN_OE, WAVE_OUT;
   int          err_count, checks;
   logic [7:0]  exp_cnt;
   logic        exp_wave;
   logic [2:0]  sel_tab [5] = '{CS_DIV1, CS_DIV8, CS_DIV64, CS_DIV256,
                                CS_DIV1024};
   int          len_tab [5] = '{16, 64, 1024, 2048, 4096};
   int          div_tab [5] = '{1, 8, 64, 256, 1024};
   logic [1:0]  act_tab [3] = '{COM_SET, COM_CLEAR, COM_TOGGLE};
   logic        fw_tab  [3] = '{1'b1, 1'b0, 1'b1};

   timer8_counter_compare_unit dut_u (
      .SYS_CLK(SYS_CLK), .RSTN(RSTN), .CTRL(CTRL),
      .PRESCALE_CLEAR(PRESCALE_CLEAR), .FORCE_MATCH(FORCE_MATCH),
      .CNT_WR(CNT_WR), .CNT_WDATA(CNT_WDATA), .CNT_RDATA(CNT_RDATA),
      .CMP_WR(CMP_WR), .CMP_WDATA(CMP_WDATA), .CMP_RDATA(CMP_RDATA),
      .MATCH_FLAG_WR1(MATCH_FLAG_WR1), .OVF_FLAG_WR1(OVF_FLAG_WR1),
      .MATCH_SERVICED(MATCH_SERVICED), .OVF_SERVICED(OVF_SERVICED),
      .MATCH_INT_EN(MATCH_INT_EN), .OVF_INT_EN(OVF_INT_EN),
      .GLOBAL_INT_EN(GLOBAL_INT_EN), .MATCH_FLAG(MATCH_FLAG),
      .OVERFLOW_FLAG(OVERFLOW_FLAG), .MATCH_IRQ(MATCH_IRQ),
      .OVF_IRQ(OVF_IRQ), .EXT_COUNT_PIN(EXT_COUNT_PIN),
      .PORT_DATA(PORT_DATA), .WAVE_PIN_DIR(WAVE_PIN_DIR),
      .WAVE_PIN_O(WAVE_PIN_O), .WAVE_PIN_OE(WAVE_PIN_OE),
      .WAVE_OUT(WAVE_OUT)
   );

   always #5 SYS_CLK = ~SYS_CLK;

   // ==========================================
   // Access tasks
   task automatic check(input string name, input logic [7:0] seen,
                        input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic bit_chk(input string name, input logic seen,
                          input logic exp);
      check(name, {7'h00, seen}, {7'h00, exp});
   endtask

   task automatic complete_run();
      $display("Comparisons %0d mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task automatic tick(input int n);
      repeat (n) @(negedge SYS_CLK);
   endtask

   task automatic wr_cnt(input logic [7:0] v);
      CNT_WDATA = v;
      CNT_WR    = 1'b1;
      tick(1);
      CNT_WR    = 1'b0;
   endtask

   task automatic wr_cmp(input logic [7:0] v);
      CMP_WDATA = v;
      CMP_WR    = 1'b1;
      tick(1);
      CMP_WR    = 1'b0;
   endtask

   task automatic force_pulse();
      FORCE_MATCH = 1'b1;
      tick(1);
      FORCE_MATCH = 1'b0;
      tick(1);
   endtask

   // Bounded wait for a counter value; runs out as a mismatch
   task automatic wait_cnt(input logic [7:0] v);
      int i;
      for (i = 0; i < 600 && CNT_RDATA !== v; i++)
         tick(1);
      if (CNT_RDATA !== v) begin
         check("wait_cnt", CNT_RDATA, v);
         complete_run();
      end
   endtask

   // Clear-on-compare run with a running expectation of count and wave
   task automatic ctc_run(input logic [1:0] act);
      CTRL = '{CS_DIV1, WGM_CTC, act};
      repeat (14) begin
         if (exp_cnt == 8'h05) begin
            exp_cnt = CNT_BOTTOM;
            if (act == COM_TOGGLE)
               exp_wave = ~exp_wave;
         end else
            exp_cnt = exp_cnt + 8'h01;
         tick(1);
         check("ctc_count", CNT_RDATA, exp_cnt);
         bit_chk("ctc_wave", WAVE_OUT, exp_wave);
      end
      CTRL.clock_select = CS_STOP;
   endtask

   // ==========================================
   // Main sequence
   initial begin
      SYS_CLK = 1'b0; RSTN = 1'b0; CTRL = '{CS_STOP, WGM_NORMAL, COM_OFF};
      {PRESCALE_CLEAR, FORCE_MATCH, CNT_WR, CMP_WR} = 4'h0;
      {MATCH_FLAG_WR1, OVF_FLAG_WR1, MATCH_SERVICED, OVF_SERVICED} = 4'h0;
      {MATCH_INT_EN, OVF_INT_EN, GLOBAL_INT_EN} = 3'h0;
      {EXT_COUNT_PIN, PORT_DATA, WAVE_PIN_DIR} = 3'h0;
      CNT_WDATA = 8'h00; CMP_WDATA = 8'h00;
      err_count = 0; checks = 0;
      tick(12);
      RSTN = 1'b1;
      tick(1);
      check("rst_cnt", CNT_RDATA, CNT_RESET);
      check("rst_cmp", CMP_RDATA, 8'h00);
      bit_chk("rst_wave", WAVE_OUT, 1'b0);
      bit_chk("rst_flag", MATCH_FLAG | OVERFLOW_FLAG, 1'b0);
      // Stopped counter keeps a written value
      wr_cnt(8'hA5);
      tick(20);
      check("stop_cnt", CNT_RDATA, 8'hA5);
      wr_cmp(8'hF0);
      check("cmp_direct", CMP_RDATA, 8'hF0);
      // Every internal division over a whole number of periods
      for (int k = 0; k < 5; k++) begin
         wr_cnt(8'h00);
         CTRL.clock_select = sel_tab[k];
         tick(len_tab[k]);
         CTRL.clock_select = CS_STOP;
         tick(2);
         check("presc", CNT_RDATA, 8'(len_tab[k] / div_tab[k]));
      end
      // Prescaler restart: first divide-by-eight tick on the eighth edge
      PRESCALE_CLEAR = 1'b1;
      wr_cnt(8'h00);
      CTRL.clock_select = CS_DIV8;
      tick(3);
      PRESCALE_CLEAR = 1'b0;
      tick(7);
      check("pre_clr_hold", CNT_RDATA, 8'h00);
      tick(1);
      CTRL.clock_select = CS_STOP;
      check("pre_clr_tick", CNT_RDATA, 8'h01);
      // External edges, falling then rising
      for (int k = 0; k < 2; k++) begin
         wr_cnt(8'h00);
         CTRL.clock_select = k ? CS_EXT_RISE : CS_EXT_FALL;
         repeat (5) begin
            EXT_COUNT_PIN = 1'b1;
            tick(4);
            EXT_COUNT_PIN = 1'b0;
            tick(4);
         end
         tick(6);
         CTRL.clock_select = CS_STOP;
         check("ext_edges", CNT_RDATA, 8'h05);
      end
      // Wrap from the maximum sets overflow
      wr_cnt(CNT_MAX);
      CTRL.clock_select = CS_DIV1;
      tick(1);
      CTRL.clock_select = CS_STOP;
      check("wrap_cnt", CNT_RDATA, CNT_BOTTOM);
      bit_chk("ovf_flag", OVERFLOW_FLAG, 1'b1);
      OVF_INT_EN = 1'b1;
      #1 bit_chk("ovf_irq_gbl0", OVF_IRQ, 1'b0);
      GLOBAL_INT_EN = 1'b1;
      #1 bit_chk("ovf_irq", OVF_IRQ, 1'b1);
      tick(1);
      OVF_FLAG_WR1 = 1'b1;
      tick(1);
      OVF_FLAG_WR1 = 1'b0;
      bit_chk("ovf_clr", OVERFLOW_FLAG, 1'b0);
      // A write beats a count in the same cycle
      CTRL.clock_select = CS_DIV1;
      tick(3);
      wr_cnt(8'h40);
      check("wr_prio", CNT_RDATA, 8'h40);
      tick(1);
      check("wr_next", CNT_RDATA, 8'h41);
      CTRL.clock_select = CS_STOP;
      // Match flag and its interrupt gating
      wr_cmp(8'h10);
      wr_cnt(8'h0E);
      CTRL.clock_select = CS_DIV1;
      wait_cnt(8'h11);
      CTRL.clock_select = CS_STOP;
      bit_chk("match_flag", MATCH_FLAG, 1'b1);
      MATCH_INT_EN = 1'b1;
      #1 bit_chk("match_irq", MATCH_IRQ, 1'b1);
      GLOBAL_INT_EN = 1'b0;
      #1 bit_chk("match_irq_g0", MATCH_IRQ, 1'b0);
      tick(1);
      MATCH_SERVICED = 1'b1;
      tick(1);
      MATCH_SERVICED = 1'b0;
      bit_chk("match_svc", MATCH_FLAG, 1'b0);
      // Write equal to compare while stopped: first match is blocked
      wr_cnt(8'h10);
      tick(3);
      CTRL.clock_select = CS_DIV1;
      wait_cnt(8'h12);
      CTRL.clock_select = CS_STOP;
      bit_chk("blocked", MATCH_FLAG, 1'b0);
      // Clear on compare, toggling and then idle action
      wr_cmp(8'h05);
      wr_cnt(8'h03);
      exp_cnt = 8'h03;
      exp_wave = 1'b0;
      ctc_run(COM_TOGGLE);
      ctc_run(COM_OFF);
      MATCH_FLAG_WR1 = 1'b1;
      tick(1);
      MATCH_FLAG_WR1 = 1'b0;
      bit_chk("match_wr1", MATCH_FLAG, 1'b0);
      // Forced matches in normal mode, then a forced match ignored in fast PWM
      CTRL = '{CS_STOP, WGM_NORMAL, COM_OFF};
      wr_cnt(8'h33);
      for (int k = 0; k < 3; k++) begin
         CTRL.output_action = act_tab[k];
         force_pulse();
         bit_chk("force_wave", WAVE_OUT, fw_tab[k]);
         bit_chk("force_flag", MATCH_FLAG, 1'b0);
         check("force_cnt", CNT_RDATA, 8'h33);
      end
      CTRL = '{CS_STOP, WGM_FAST, COM_CLEAR};
      bit_chk("mode_keep", WAVE_OUT, 1'b1);
      force_pulse();
      bit_chk("force_pwm", WAVE_OUT, 1'b1);
      // Pin source and direction
      WAVE_PIN_DIR = 1'b1;
      CTRL.output_action = COM_OFF;
      #1 bit_chk("pin_port", WAVE_PIN_O, 1'b0);
      bit_chk("pin_oe", WAVE_PIN_OE, 1'b1);
      CTRL.output_action = COM_TOGGLE;
      #1 bit_chk("pin_wave", WAVE_PIN_O, 1'b1);
      WAVE_PIN_DIR = 1'b0;
      #1 bit_chk("pin_dir", WAVE_PIN_OE, 1'b0);
      // Fast PWM with buffered compare
      tick(1);
      CTRL = '{CS_STOP, WGM_NORMAL, COM_OFF};
      wr_cmp(8'h20);
      CTRL = '{CS_STOP, WGM_FAST, COM_CLEAR};
      wr_cmp(8'h80);
      check("cmp_buf", CMP_RDATA, 8'h80);
      wr_cnt(8'h10);
      CTRL.clock_select = CS_DIV1;
      wait_cnt(8'h21);
      bit_chk("pwm_old_cmp", WAVE_OUT, 1'b0);
      wait_cnt(CNT_BOTTOM);
      bit_chk("pwm_max_set", WAVE_OUT, 1'b1);
      bit_chk("pwm_ovf", OVERFLOW_FLAG, 1'b1);
      wait_cnt(8'h21);
      bit_chk("pwm_new_cmp", WAVE_OUT, 1'b1);
      wait_cnt(8'h81);
      bit_chk("pwm_match", WAVE_OUT, 1'b0);
      CTRL.clock_select = CS_STOP;
      tick(2);
      // Phase correct mode turns the count round at the maximum
      CTRL = '{CS_STOP, WGM_PCPWM, COM_OFF};
      wr_cnt(8'hFE);
      CTRL.clock_select = CS_DIV1;
      tick(1);
      check("pc_up", CNT_RDATA, CNT_MAX);
      tick(1);
      CTRL.clock_select = CS_STOP;
      check("pc_down", CNT_RDATA, 8'hFE);
      tick(2);
      complete_run();
   end
endmodule

`default_nettype wire
